/* File: design/amd_decoder.v */
`timescale 1ns/100ps
`include "amd_map.vh"
module amd_decoder (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // instruction descriptor from opcode logic
  input wire start,
  input wire [1:0] bas_len,
  input wire [1:0] gen_cnt,
  input wire [4:0] g0_pos,
  input wire [4:0] g1_pos,
  input wire [4:0] f4_pos,
  input wire [2:0] imm_len,
  input wire [1:0] op_wr,
  input wire [3:0] op_len,
  input wire [1:0] imp_cnt,
  input wire [1:0] imp_kind,
  // prefetch queue bytes
  input wire q_valid,
  input wire [7:0] q_data,
  output wire q_ready,
  // register file view
  input wire [255:0] gpr_flat,
  input wire [31:0] frame_pointer,
  input wire [31:0] static_base_pointer,
  input wire [31:0] program_counter,
  input wire [31:0] interrupt_stack_pointer,
  input wire [31:0] user_stack_pointer,
  input wire flags_s,
  input wire [31:0] link_base,
  // pointer reads
  output wire mem_req,
  output reg [31:0] mem_addr,
  input wire mem_ack,
  input wire [31:0] mem_data,
  // stack pointer update
  output reg sp_upd,
  output reg [31:0] sp_new,
  // operand results
  output reg res_valid,
  output reg res_op,
  output reg [1:0] res_cls,
  output reg [2:0] res_reg,
  output reg [31:0] res_ea,
  output reg [31:0] res_imm,
  output reg res_bad,
  output reg [15:0] lnk_desc,
  output reg [15:0] lnk_off,
  // implied extensions
  output reg imp_valid,
  output reg [31:0] imp_val,
  // short field and status
  output reg [3:0] f4_raw,
  output reg [31:0] f4_short,
  output wire busy,
  output reg done
);

  // finished displacement, sign extended
  function [31:0] fin_disp;
    input [31:0] f;
    input [2:0] l;
    begin
      case (l)
        3'd1: fin_disp = {{25{f[6]}}, f[6:0]};
        3'd2: fin_disp = {{18{f[13]}}, f[13:0]};
        default: fin_disp = {{2{f[29]}}, f[29:0]};
      endcase
    end
  endfunction

  // finished immediate, zero extended
  function [31:0] fin_imm;
    input [31:0] f;
    input [2:0] l;
    begin
      case (l)
        3'd1: fin_imm = {24'h000000, f[7:0]};
        3'd2: fin_imm = {16'h0000, f[15:0]};
        default: fin_imm = f;
      endcase
    end
  endfunction

  // -------------------------------------------------
  // state
  // -------------------------------------------------
  reg [3:0] st_r; // sequencer state
  reg [23:0] basic_r; // basic instruction bytes
  reg [1:0] bcnt_r; // basic bytes taken
  reg [1:0] blen_r, gcnt_r, wr_r, imp_r, ik_r;
  reg [4:0] p0_r, p1_r, p4_r; // field positions
  reg [2:0] ilen_r; // immediate size
  reg [3:0] olen_r; // operand size
  reg [4:0] m0_r, m1_r; // mode fields
  reg [7:0] ix0_r, ix1_r; // index bytes
  reg [1:0] need_r; // index bytes pending
  reg opi_r; // current operand
  reg [1:0] dn_r; // fields pending
  reg fresh_r; // next byte opens a field
  reg [1:0] cnt_r; // bytes left in field
  reg [2:0] len_r; // field length
  reg [23:0] acc_r; // field bytes so far
  reg [31:0] d1_r, d2_r, ptr_r, imm_r;
  reg [31:0] sp_r; // working stack pointer
  reg dbad_r; // reserved pattern seen

  // -------------------------------------------------
  // current operand decode
  // -------------------------------------------------
  wire [4:0] cm = opi_r ? m1_r : m0_r;
  wire [7:0] cix = opi_r ? ix1_r : ix0_r;
  wire scl = (cm[4:2] == `AMD_M_SCL);
  wire [4:0] bm = scl ? cix[7:3] : cm;
  wire is_imm = (bm == `AMD_M_IMM);
  wire cwr = opi_r ? wr_r[1] : wr_r[0];
  wire mrel = (bm[4:2] == 3'b100) && (bm[1:0] != 2'b11);
  wire twod = mrel || (bm == `AMD_M_EXT);
  wire [31:0] g_b = gpr_flat[{bm[2:0], 5'h00} +: 32];
  wire [31:0] g_x = gpr_flat[{cix[2:0], 5'h00} +: 32];
  wire [31:0] olen32 = {28'h0000000, olen_r};
  wire [23:0] sh0 = basic_r >> p0_r;
  wire [23:0] sh1 = basic_r >> p1_r;
  wire [23:0] sh4 = basic_r >> p4_r;

  // -------------------------------------------------
  // byte assembly
  // -------------------------------------------------
  // index state opens the queue only while an index byte is owed,
  // otherwise it would swallow the first extension byte
  assign q_ready = (st_r == `AMD_S_BAS) ||
                   ((st_r == `AMD_S_IDX) && (need_r != 2'b00)) ||
                   (st_r == `AMD_S_EXT) || (st_r == `AMD_S_IMPL);
  wire take = q_valid && q_ready;
  wire want_imm = (st_r == `AMD_S_EXT) ? is_imm : ik_r[0];
  wire [2:0] ilen = (st_r == `AMD_S_EXT) ? ilen_r : 3'd1;
  wire [2:0] dlen = !q_data[7] ? 3'd1 : (!q_data[6] ? 3'd2 : 3'd4);
  wire [2:0] flen = want_imm ? ilen : dlen;
  wire [2:0] clen = fresh_r ? flen : len_r;
  wire last = fresh_r ? (flen == 3'd1) : (cnt_r == 2'd1);
  wire [31:0] full = {fresh_r ? 24'h000000 : acc_r, q_data};
  wire [31:0] dval = fin_disp(full, clen);
  wire [31:0] ival = fin_imm(full, clen);
  wire [31:0] fval = want_imm ? ival : dval;
  wire [2:0] fcnt = flen - 3'd1;

  // -------------------------------------------------
  // pointer address and effective address
  // -------------------------------------------------
  reg [31:0] mbase, ea_b, ea;
  always @* begin
    case (bm[1:0])
      2'b00: mbase = frame_pointer;
      2'b01: mbase = sp_r;
      default: mbase = static_base_pointer;
    endcase
    if (bm == `AMD_M_EXT)
      mem_addr = link_base + {d1_r[29:0], 2'b00};
    else
      mem_addr = mbase + d1_r;
    case (bm)
      5'h10, 5'h11, 5'h12, `AMD_M_EXT: ea_b = ptr_r + d2_r;
      `AMD_M_ABS: ea_b = d1_r;
      `AMD_M_TOS: ea_b = cwr ? sp_r - olen32 : sp_r;
      `AMD_M_MFP: ea_b = frame_pointer + d1_r;
      `AMD_M_MSP: ea_b = sp_r + d1_r;
      `AMD_M_MSB: ea_b = static_base_pointer + d1_r;
      `AMD_M_MPC: ea_b = program_counter + d1_r;
      default: ea_b = g_b + d1_r;
    endcase
    ea = scl ? ea_b + (g_x << cm[1:0]) : ea_b;
  end
  assign mem_req = (st_r == `AMD_S_PTR);
  assign busy = (st_r != `AMD_S_IDLE);

  // -------------------------------------------------
  // sequencer
  // -------------------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= `AMD_S_IDLE;
      basic_r <= 24'h000000;
      bcnt_r <= 2'h0;
      blen_r <= 2'h0;
      gcnt_r <= 2'h0;
      wr_r <= 2'h0;
      imp_r <= 2'h0;
      ik_r <= 2'h0;
      p0_r <= 5'h00;
      p1_r <= 5'h00;
      p4_r <= 5'h00;
      ilen_r <= 3'h0;
      olen_r <= 4'h0;
      m0_r <= 5'h00;
      m1_r <= 5'h00;
      ix0_r <= 8'h00;
      ix1_r <= 8'h00;
      need_r <= 2'h0;
      opi_r <= 1'b0;
      dn_r <= 2'h0;
      fresh_r <= 1'b1;
      cnt_r <= 2'h0;
      len_r <= 3'h0;
      acc_r <= 24'h000000;
      d1_r <= 32'h00000000;
      d2_r <= 32'h00000000;
      ptr_r <= 32'h00000000;
      imm_r <= 32'h00000000;
      sp_r <= 32'h00000000;
      dbad_r <= 1'b0;
      sp_upd <= 1'b0;
      sp_new <= 32'h00000000;
      res_valid <= 1'b0;
      res_op <= 1'b0;
      res_cls <= 2'h0;
      res_reg <= 3'h0;
      res_ea <= 32'h00000000;
      res_imm <= 32'h00000000;
      res_bad <= 1'b0;
      lnk_desc <= 16'h0000;
      lnk_off <= 16'h0000;
      imp_valid <= 1'b0;
      imp_val <= 32'h00000000;
      f4_raw <= 4'h0;
      f4_short <= 32'h00000000;
      done <= 1'b0;
    end else begin
      // pulses default low
      sp_upd <= 1'b0;
      res_valid <= 1'b0;
      imp_valid <= 1'b0;
      done <= 1'b0;
      // field assembly common to extensions
      if (take && (st_r == `AMD_S_EXT || st_r == `AMD_S_IMPL)) begin
        len_r <= clen;
        cnt_r <= fresh_r ? fcnt[1:0] : cnt_r - 2'd1;
        acc_r <= full[23:0];
        fresh_r <= last;
        if (fresh_r && !want_imm && q_data == `AMD_DISP_RSV)
          dbad_r <= 1'b1;
      end
      case (st_r)
        `AMD_S_IDLE: begin
          if (start) begin
            blen_r <= bas_len;
            gcnt_r <= gen_cnt;
            p0_r <= g0_pos;
            p1_r <= g1_pos;
            p4_r <= f4_pos;
            ilen_r <= imm_len;
            wr_r <= op_wr;
            olen_r <= op_len;
            imp_r <= imp_cnt;
            ik_r <= imp_kind;
            basic_r <= 24'h000000;
            bcnt_r <= 2'h0;
            opi_r <= 1'b0;
            sp_r <= flags_s ? user_stack_pointer :
                    interrupt_stack_pointer;
            st_r <= `AMD_S_BAS;
          end
        end
        `AMD_S_BAS: begin
          if (take) begin
            basic_r[{bcnt_r, 3'b000} +: 8] <= q_data;
            bcnt_r <= bcnt_r + 2'd1;
            if (bcnt_r + 2'd1 >= blen_r)
              st_r <= `AMD_S_GEN;
          end
        end
        // extract mode and four bit fields
        `AMD_S_GEN: begin
          m0_r <= sh0[4:0];
          m1_r <= sh1[4:0];
          f4_raw <= sh4[3:0];
          f4_short <= {{28{sh4[3]}}, sh4[3:0]};
          // one index byte per scaled mode
          need_r[0] <= (gcnt_r != 2'd0) && (sh0[4:2] == `AMD_M_SCL);
          need_r[1] <= (gcnt_r == 2'd2) && (sh1[4:2] == `AMD_M_SCL);
          st_r <= `AMD_S_IDX;
        end
        `AMD_S_IDX: begin
          if (need_r == 2'b00)
            st_r <= (gcnt_r != 2'd0) ? `AMD_S_OPB :
                    (imp_r != 2'd0) ? `AMD_S_IMPL : `AMD_S_IDLE;
          if (need_r == 2'b00 && gcnt_r == 2'd0 && imp_r == 2'd0)
            done <= 1'b1;
          if (take) begin
            if (need_r[0]) begin
              ix0_r <= q_data;
              need_r[0] <= 1'b0;
            end else begin
              ix1_r <= q_data;
              need_r[1] <= 1'b0;
            end
          end
        end
        // operand begin: count its fields
        `AMD_S_OPB: begin
          fresh_r <= 1'b1;
          dbad_r <= 1'b0;
          if (bm[4:3] == 2'b01 || bm == `AMD_M_ABS || is_imm ||
              bm[4:2] == 3'b110)
            dn_r <= 2'd1;
          else if (twod)
            dn_r <= 2'd2;
          else
            dn_r <= 2'd0;
          if (bm[4:3] == 2'b01 || bm == `AMD_M_ABS || is_imm ||
              bm[4:2] == 3'b110 || twod)
            st_r <= `AMD_S_EXT;
          else
            st_r <= `AMD_S_FIN;
        end
        `AMD_S_EXT: begin
          if (take && last) begin
            if (is_imm)
              imm_r <= ival;
            else if (dn_r == 2'd2 || !twod)
              d1_r <= dval;
            else
              d2_r <= dval;
            dn_r <= dn_r - 2'd1;
            if (dn_r == 2'd1)
              st_r <= twod ? `AMD_S_PTR : `AMD_S_FIN;
          end
        end
        // pointer fetch, stalls until acknowledged
        `AMD_S_PTR: begin
          if (mem_ack) begin
            ptr_r <= mem_data;
            lnk_desc <= mem_data[15:0];
            lnk_off <= mem_data[31:16];
            st_r <= `AMD_S_FIN;
          end
        end
        `AMD_S_FIN: begin
          res_valid <= 1'b1;
          res_op <= opi_r;
          res_reg <= bm[2:0];
          res_imm <= imm_r;
          res_ea <= ea;
          res_cls <= (bm[4:3] == 2'b00 && !scl) ? `AMD_CLS_REG :
                     is_imm ? `AMD_CLS_IMM : `AMD_CLS_MEM;
          res_bad <= (bm == `AMD_M_RSV) || dbad_r ||
                     (scl && (is_imm || bm[4:2] == `AMD_M_SCL)) ||
                     (is_imm && cwr);
          // top of stack push or pop
          if (bm == `AMD_M_TOS) begin
            sp_upd <= 1'b1;
            sp_new <= cwr ? sp_r - olen32 : sp_r + olen32;
            sp_r <= cwr ? sp_r - olen32 : sp_r + olen32;
          end
          fresh_r <= 1'b1;
          if (!opi_r && gcnt_r == 2'd2) begin
            opi_r <= 1'b1;
            st_r <= `AMD_S_OPB;
          end else if (imp_r != 2'd0) begin
            st_r <= `AMD_S_IMPL;
          end else begin
            done <= 1'b1;
            st_r <= `AMD_S_IDLE;
          end
        end
        `AMD_S_IMPL: begin
          if (take && last) begin
            imp_valid <= 1'b1;
            imp_val <= fval;
            ik_r <= {1'b0, ik_r[1]};
            imp_r <= imp_r - 2'd1;
            if (imp_r == 2'd1) begin
              done <= 1'b1;
              st_r <= `AMD_S_IDLE;
            end
          end
        end
        default: st_r <= `AMD_S_IDLE;
      endcase
    end
  end

endmodule // amd_decoder

/* File: inc/amd_map.vh */
// Operation
// - basic bytes hold opcode and two modes
// - scaled mode takes one index byte
// - scaled codes add index times 1,2,4,8
// - extensions follow index bytes in order
// - displacement length from top bits, signed
// - extensions assembled most significant first
// - implied extensions taken from instruction end
// - implied immediate is one byte
// - 8, 16, 32 bit displacements legal
// - codes 0-7 select general register
// - codes 8-15 register plus displacement
// - memory relative reads pointer then adds
// - code 10011 reserved and flagged
// - immediate from queue, never written
// - absolute uses displacement alone
// - external reads link table entry pointer
// - top of stack pushes or pops
// - memory space displacement plus base register
// - no index on immediate or index
// - link entry address or two halves
// - four bit short and condition fields
// - stack select bit picks stack pointer
// - push pre-decrements, pop post-increments
`ifndef AMD_MAP_VH
`define AMD_MAP_VH
// -------------------------------------------------
// sequencer states
// -------------------------------------------------
`define AMD_S_IDLE 4'h0
`define AMD_S_BAS 4'h1
`define AMD_S_GEN 4'h2
`define AMD_S_IDX 4'h3
`define AMD_S_OPB 4'h4
`define AMD_S_EXT 4'h5
`define AMD_S_PTR 4'h6
`define AMD_S_FIN 4'h7
`define AMD_S_IMPL 4'h8
// -------------------------------------------------
// mode encodings
// -------------------------------------------------
`define AMD_M_RSV 5'h13
`define AMD_M_IMM 5'h14
`define AMD_M_ABS 5'h15
`define AMD_M_EXT 5'h16
`define AMD_M_TOS 5'h17
`define AMD_M_MFP 5'h18
`define AMD_M_MSP 5'h19
`define AMD_M_MSB 5'h1A
`define AMD_M_MPC 5'h1B
`define AMD_M_SCL 3'h7
// reserved leading displacement byte
`define AMD_DISP_RSV 8'hE0
// -------------------------------------------------
// operand classes
// -------------------------------------------------
`define AMD_CLS_REG 2'h0
`define AMD_CLS_MEM 2'h1
`define AMD_CLS_IMM 2'h2
`endif

/* File: test/amd_feeder.sv */
`timescale 1ns/100ps
// ----
// queue feeder and pointer memory
// ----
module amd_feeder (
  // clock and reset
  input logic sys_clk,
  input logic reset_n,
  // bench control
  input logic ld,
  input logic slow,
  // queue bytes
  input logic q_ready,
  output logic q_valid,
  output logic [7:0] q_data,
  // pointer reads
  input logic mem_req,
  input logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_data
);
  logic [7:0] bq [0:15]; // instruction bytes
  int bn = 0; // bytes loaded
  int ptr_r; // next byte offered
  logic gap_r; // stall cycle in slow mode
  logic [7:0] last_r; // last byte taken
  logic [1:0] wait_r; // read latency count
  assign q_valid = (ptr_r < bn) && !gap_r;
  // a line not offered shows the inverse of the last byte
  assign q_data = q_valid ? bq[ptr_r] : ~last_r;
  // byte stepping and pointer answers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r <= 0;
      gap_r <= 1'b0;
      last_r <= 8'h00;
      wait_r <= 2'h0;
      mem_ack <= 1'b0;
      mem_data <= 32'h0;
    end else begin
      gap_r <= 1'b0;
      mem_ack <= 1'b0;
      // idle read data changes every cycle
      mem_data <= ~mem_data;
      if (ld) begin
        ptr_r <= 0;
      end else if (q_valid && q_ready) begin
        ptr_r <= ptr_r + 1;
        gap_r <= slow;
        last_r <= q_data;
      end
      // answer a held request, promptly or late
      if (mem_req && !mem_ack) begin
        wait_r <= wait_r + 2'h1;
        if (wait_r >= {slow, 1'b0}) begin
          mem_ack <= 1'b1;
          mem_data <= mem_addr ^ 32'h0F0F0000;
          wait_r <= 2'h0;
        end
      end
    end
  end
endmodule // amd_feeder

/* File: test/amd_decoder_properties.sv */
`timescale 1ns/100ps
// ----
// port checks of the decoder
// ----
module amd_decoder_properties (
  // clock and reset
  input logic sys_clk,
  input logic reset_n,
  // descriptor and status
  input logic start,
  input logic [1:0] gen_cnt,
  input logic [1:0] op_wr,
  input logic [3:0] op_len,
  input logic flags_s,
  input logic [31:0] interrupt_stack_pointer,
  input logic [31:0] user_stack_pointer,
  input logic busy,
  input logic done,
  // queue and pointer reads
  input logic q_ready,
  input logic mem_req,
  input logic [31:0] mem_addr,
  input logic mem_ack,
  // results
  input logic sp_upd,
  input logic [31:0] sp_new,
  input logic res_valid,
  input logic res_op,
  input logic [1:0] res_cls,
  input logic res_bad,
  input logic imp_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // stack pointer picked by the select bit
  wire [31:0] sp_sel = flags_s ? user_stack_pointer : interrupt_stack_pointer;
  sequence s_start;
    start && !busy;
  endsequence
  sequence s_ptr_done;
    mem_req && mem_ack;
  endsequence
  a_start_busy: assert property (s_start |=> busy)
    else $error("busy not raised after start");
  a_idle_quiet: assert property (!busy |-> !q_ready && !mem_req)
    else $error("queue or read active while idle");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_ptr_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr))
    else $error("pointer read dropped or moved");
  a_ptr_result: assert property (s_ptr_done |=>
    !mem_req ##[0:2] res_valid)
    else $error("no result after pointer read");
  // queue paused during a pointer read
  a_ptr_quiet: assert property (mem_req |-> !q_ready)
    else $error("queue open during pointer read");
  a_imm_written: assert property (res_valid && res_cls == 2'h2
    && op_wr[res_op] |-> res_bad)
    else $error("written immediate not flagged");
  a_sp_pop: assert property (sp_upd && op_wr == 2'h0 |->
    sp_new == sp_sel + op_len)
    else $error("pop pointer wrong");
  a_sp_push: assert property (sp_upd && gen_cnt == 2'h1 && op_wr[0] |->
    sp_new == sp_sel - op_len)
    else $error("push pointer wrong");
  a_imp_after: assert property (imp_valid |-> !res_valid)
    else $error("implied value overlaps a result");
endmodule // amd_decoder_properties
bind amd_decoder amd_decoder_properties u_amd_decoder_properties (.*);

/* File: test/tb.sv */
`timescale 1ns/100ps
module tb;
  // ----
  // design and model signals
  // ----
  logic sys_clk = 0, reset_n = 0, start = 0, flags_s = 0, ld = 0, slow = 0;
  logic [1:0] bas_len = 2, gen_cnt = 1, op_wr = 0, imp_cnt = 0, imp_kind = 1;
  logic [4:0] g0_pos = 11, g1_pos = 6, f4_pos = 2;
  logic [2:0] imm_len = 4, res_reg;
  logic [3:0] op_len = 4, f4_raw;
  logic q_valid, q_ready, mem_req, mem_ack, sp_upd, res_valid, res_op;
  logic res_bad, imp_valid, busy, done;
  logic [7:0] q_data;
  logic [255:0] gpr_flat;
  logic [31:0] frame_pointer = 32'h40000000, static_base_pointer = 32'h2000;
  logic [31:0] program_counter = 32'h80000010, link_base = 32'h3000;
  logic [31:0] interrupt_stack_pointer = 32'h1000;
  logic [31:0] user_stack_pointer = 32'h7000;
  logic [31:0] mem_addr, mem_data, sp_new, res_ea, res_imm, imp_val, f4_short;
  logic [1:0] res_cls;
  logic [15:0] lnk_desc, lnk_off;
  // captured results
  logic [31:0] ea [2], im [2], iv [2], spn, ma;
  logic [1:0] cl [2];
  logic [2:0] rg [2];
  logic bd [2];
  int ni, errors = 0, checked = 0;
  bit dn;
  localparam logic [31:0] PK = 32'h0F0F0000; // model read scramble
  amd_decoder u_amd_decoder (.*);
  amd_feeder u_amd_feeder (.*);
  always #10 sys_clk = ~sys_clk;
  // capture pulses as they stand
  always @(posedge sys_clk) begin
    if (res_valid) begin
      ea[res_op] = res_ea;
      cl[res_op] = res_cls;
      rg[res_op] = res_reg;
      bd[res_op] = res_bad;
      im[res_op] = res_imm;
    end
    if (sp_upd) spn = sp_new;
    if (mem_req && mem_ack) ma = mem_addr;
    if (imp_valid && ni < 2) begin
      iv[ni] = imp_val;
      ni++;
    end
    if (done) dn = 1;
  end
  // ----
  // helpers
  // ----
  function automatic logic [31:0] gv(input int n);
    return n == 3 ? 32'h0 : 32'h1000 * n + 32'h20;
  endfunction
  // basic word, low byte first
  function automatic logic [15:0] bw(input logic [4:0] a, b,
    input logic [3:0] f);
    logic [15:0] w;
    w = {a, b, f, 2'b10};
    return {w[7:0], w[15:8]};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    checked++;
    if (a !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, a);
    end
  endtask
  task setd(input logic [1:0] gc, wr, input logic s, input logic [1:0] ic);
    @(posedge sys_clk);
    gen_cnt <= gc;
    op_wr <= wr;
    flags_s <= s;
    imp_cnt <= ic;
  endtask
  task run(input logic [127:0] v, input int n);
    int i;
    for (i = 0; i < n; i++) u_amd_feeder.bq[i] = v[8*(n-1-i) +: 8];
    u_amd_feeder.bn = n;
    for (i = 0; i < 2; i++) begin
      ea[i] = 'x; cl[i] = 'x; rg[i] = 'x; bd[i] = 'x; im[i] = 'x; iv[i] = 'x;
    end
    spn = 'x; ma = 'x; ni = 0; dn = 0;
    @(posedge sys_clk);
    start <= 1;
    ld <= 1;
    @(posedge sys_clk);
    start <= 0;
    ld <= 0;
    for (i = 0; i < 300 && !dn; i++) @(posedge sys_clk);
    chk("done", 1, dn);
  endtask
  task wrap_up;
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task t_reg;
    setd(1, 0, 0, 0);
    run(bw(5'h05, 0, 4'hA), 2);
    chk("cls", 0, cl[0]);
    chk("reg", 5, rg[0]);
    chk("f4", 4'hA, f4_raw);
    chk("f4s", 32'hFFFFFFFA, f4_short);
  endtask
  task t_rel;
    setd(2, 0, 0, 0);
    run({bw(5'h0B, 5'h08, 0), 8'h7F, 16'h9FFF}, 5);
    chk("ea0", 32'hFFFFFFFF, ea[0]);
    chk("ea1", gv(0) + 8191, ea[1]);
    run({bw(5'h0B, 5'h08, 0), 8'h40, 16'hA000}, 5);
    chk("ea0", -64, ea[0]);
    chk("ea1", gv(0) - 8192, ea[1]);
  endtask
  task t_spc;
    setd(2, 0, 1, 0);
    // leading byte kept off the reserved value
    run({bw(5'h19, 5'h1B, 0), 32'hC0000100, 8'h3F}, 7);
    chk("usp", user_stack_pointer + 32'h100, ea[0]);
    chk("pc", program_counter + 63, ea[1]);
    setd(2, 0, 0, 0);
    run({bw(5'h18, 5'h1A, 0), 8'h01, 8'h02}, 4);
    chk("fp", frame_pointer + 1, ea[0]);
    chk("sb", static_base_pointer + 2, ea[1]);
  endtask
  task t_mrel;
    int m;
    logic [31:0] b;
    setd(1, 0, 0, 0);
    slow <= 1;
    for (m = 0; m < 3; m++) begin
      b = m == 0 ? frame_pointer : m == 1 ? interrupt_stack_pointer
        : static_base_pointer;
      run({bw(5'(16 + m), 0, 0), 8'h04, 8'h08}, 4);
      chk("ptr", b + 4, ma);
      chk("ea", ((b + 4) ^ PK) + 8, ea[0]);
    end
    slow <= 0;
  endtask
  task t_ext;
    logic [31:0] p;
    setd(1, 0, 0, 0);
    run({bw(5'h16, 0, 0), 8'h03, 8'h7E}, 4);
    p = (link_base + 12) ^ PK;
    chk("ptr", link_base + 12, ma);
    chk("ea", p - 2, ea[0]);
    chk("desc", p[15:0], lnk_desc);
    chk("off", p[31:16], lnk_off);
  endtask
  task t_idx;
    int s;
    setd(1, 0, 0, 0);
    for (s = 0; s < 4; s++) begin
      run({bw(5'(28 + s), 0, 0), 5'h15, 3'd6, 8'h10}, 4);
      chk("ea", 32'h10 + (gv(6) << s), ea[0]);
    end
    run({bw(5'h1C, 0, 0), 5'h14, 3'd1, 32'h1}, 7);
    chk("bad", 1, bd[0]);
  endtask
  task t_imm;
    setd(1, 0, 0, 0);
    run({bw(5'h14, 0, 0), 32'h12345678}, 6);
    chk("cls", 2, cl[0]);
    chk("imm", 32'h12345678, im[0]);
    setd(1, 1, 0, 0);
    run({bw(5'h14, 0, 0), 32'h12345678}, 6);
    chk("bad", 1, bd[0]);
    setd(1, 0, 0, 0);
    run(bw(5'h13, 0, 0), 2);
    chk("bad", 1, bd[0]);
  endtask
  task t_tos;
    setd(1, 0, 0, 0);
    run(bw(5'h17, 0, 0), 2);
    chk("ea", interrupt_stack_pointer, ea[0]);
    chk("sp", interrupt_stack_pointer + 4, spn);
    setd(1, 1, 1, 0);
    op_len <= 2;
    run(bw(5'h17, 0, 0), 2);
    chk("ea", user_stack_pointer - 2, ea[0]);
    chk("sp", user_stack_pointer - 2, spn);
    op_len <= 4;
  endtask
  task t_imp;
    setd(1, 0, 0, 2);
    run({bw(5'h08, 0, 0), 8'h02, 8'h85, 16'h8123}, 6);
    chk("ea", gv(0) + 2, ea[0]);
    chk("imp0", 32'h85, iv[0]);
    chk("imp1", 32'h123, iv[1]);
  endtask
  // ----
  // main sequence and watchdog
  // ----
  initial begin
    for (int i = 0; i < 8; i++) gpr_flat[32*i +: 32] = gv(i);
    repeat (20) @(posedge sys_clk);
    reset_n <= 1;
    @(posedge sys_clk);
    t_reg;
    t_rel;
    t_spc;
    t_mrel;
    t_ext;
    t_idx;
    t_imm;
    t_tos;
    t_imp;
    wrap_up;
  end
  initial begin
    #400000;
    errors++;
    wrap_up;
  end
endmodule // tb
